// ---- rtl/bw_cap_pkg.sv ----
// Constants and types for the partition narrowing and bandwidth ceiling block
package bw_cap_pkg;
	// Register offsets within each security-state feature frame
	localparam logic [11:0] NARROW_MAP_OFFSET = 12'h600;
	localparam logic [11:0] BW_CEILING_OFFSET = 12'h208;
	// Security states, one register frame each
	localparam int STATE_COUNT = 4;
	localparam logic [1:0] SEC_SECURE = 2'h0;
	localparam logic [1:0] SEC_NONSECURE = 2'h1;
	localparam logic [1:0] SEC_ROOT = 2'h2;
	localparam logic [1:0] SEC_REALM = 2'h3;
	// Request and narrowed identifier spaces
	localparam int REQ_ID_BITS = 4;
	localparam int INT_ID_BITS = 3;
	localparam int INT_ID_COUNT = 8;
	localparam int MAP_ADDR_BITS = 6;
	localparam int MAP_DEPTH = 64;
	localparam logic [15:0] NARROWED_ID_LIMIT = 16'h0007;
	// Resource instances
	localparam logic RESOURCE_INSTANCES_SUPPORTED = 1'b1;
	localparam int RES_INSTANCES = 2;
	localparam int RIS_BITS = 1;
	localparam int REGULATED_INSTANCE = 0;
	// Field positions
	localparam int FLAG_BIT = 16;
	localparam int HARD_LIMIT_BIT = 31;
	localparam int FRACTION_MSB = 15;
	localparam int FRACTION_WIDTH = 3;
	// Reset values
	localparam logic [15:0] MAP_RESET = 16'h0000;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic [2:0] FRACTION_RESET = 3'h7;
	localparam logic HARD_RESET = 1'b0;
	// Measurement window of 2**WINDOW_BITS cycles
	localparam int WINDOW_BITS = 8;
	localparam int SLOT_COUNT = 32;
	// Error codes toward the error status register
	localparam logic [1:0] ERR_NONE = 2'h0;
	localparam logic [1:0] ERR_RANGE = 2'h1;
	localparam logic [1:0] ERR_UNEXPECTED = 2'h2;
	// Register access sequencer; one bit changes per step except answer back to idle
	typedef enum logic [1:0] {
		ACC_IDLE = 2'h0,
		ACC_LOOKUP = 2'h1,
		ACC_ANSWER = 2'h3
	} access_state_type;
endpackage

// ---- rtl/map_mem_if.sv ----
// Port bundle between the register logic and the narrowing map store
`timescale 1ns/1ps
interface map_mem_if;
	import bw_cap_pkg::*;
	logic we; // Write strobe
	logic [MAP_ADDR_BITS-1:0] waddr; // Write entry
	logic [15:0] wdata; // Narrowed identifier to store
	logic [MAP_ADDR_BITS-1:0] raddr; // Read entry
	logic [15:0] rdata; // Registered read data
	modport owner (output we, output waddr, output wdata, output raddr,
		input rdata);
	modport store (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface

// ---- rtl/map_store.sv ----
// Narrowing map table, one entry per security state and request identifier
`timescale 1ns/1ps
module map_store
	import bw_cap_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Table access
	map_mem_if.store mem
);
	logic [15:0] table_q [MAP_DEPTH]; // Stored associations
	logic [15:0] rdata_q; // Read data register

	// Reset clears the table so unwritten entries read a defined zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < MAP_DEPTH; i++) begin
				table_q[i] <= MAP_RESET;
			end
		end else if (mem.we) begin
			table_q[mem.waddr] <= mem.wdata;
		end
	end

	// Read data always leaves through a register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= MAP_RESET;
		end else begin
			rdata_q <= table_q[mem.raddr];
		end
	end

	assign mem.rdata = rdata_q;
endmodule

// ---- rtl/partition_narrowing_bw_cap.sv ----
// Partition narrowing map and bandwidth ceiling registers with regulator
// Behaviour
// [RULE1] Hold request-to-narrowed association per selected identifier
// [RULE2] Software selects request identifier, then writes map
// [RULE3] Software selects identifier, then reads map
// [RULE4] Out-of-range or flag-clear write: no update, error
// [RULE5] Selector internal flag set on access: error
// [RULE6] Flag bit 16 written zero blocks update
// [RULE7] Bit 16 reads back last written flag
// [RULE8] Bits 15:0 narrowed id, 31:17 reserved
// [RULE9] Four separate per-state narrowing instances
// [RULE10] Narrowing access ignores resource instance select
// [RULE11] Access targets selector id; internal flag zero
// [RULE12] Narrowing map answers at offset 0x0600
// [RULE13] Ceiling access uses selected instance and partition
// [RULE14] Soft limit: over-limit served only when idle
// [RULE15] Hard limit: no grants while over maximum
// [RULE16] Ceiling: fraction 15:0, hard flag bit 31
// [RULE17] Only top fraction bits kept, rest zero
// [RULE18] Fraction below one, point above bit 15
// [RULE19] Separate ceiling settings per security state
// [RULE20] Measure usage per window, compare with ceiling
`timescale 1ns/1ps
module partition_narrowing_bw_cap
	import bw_cap_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register access from the feature frames
	input wire logic reg_valid,
	input wire logic reg_write,
	input wire logic [1:0] reg_state,
	input wire logic [11:0] reg_offset,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata_q,
	output logic reg_ack_q,
	output logic reg_busy_q,
	// Selector fields, one set per security state
	input wire logic [15:0] sel_partition [STATE_COUNT],
	input wire logic sel_internal [STATE_COUNT],
	input wire logic [RIS_BITS-1:0] sel_instance [STATE_COUNT],
	// Error report toward the error status register
	output logic err_event_q,
	output logic [1:0] err_code_q,
	output logic [1:0] err_state_q,
	// Regulated traffic, slot index is state * 8 + narrowed id
	input wire logic [SLOT_COUNT-1:0] traffic_req,
	output logic [SLOT_COUNT-1:0] grant_q,
	output logic [SLOT_COUNT-1:0] over_limit_q
);
	access_state_type acc_q; // Access sequencer state
	access_state_type acc_d; // Next sequencer state
	logic op_write_q; // Captured direction
	logic [1:0] op_state_q; // Captured security state
	logic [11:0] op_offset_q; // Captured offset
	logic [31:0] op_wdata_q; // Captured write data
	logic [15:0] op_part_q; // Captured selector identifier
	logic op_internal_q; // Captured selector internal flag
	logic [RIS_BITS-1:0] op_ris_q; // Captured resource instance
	logic flag_q [STATE_COUNT]; // Last written flag per state
	logic [FRACTION_WIDTH-1:0] frac_q [STATE_COUNT][RES_INSTANCES]
		[INT_ID_COUNT]; // Implemented ceiling bits
	logic hard_q [STATE_COUNT][RES_INSTANCES][INT_ID_COUNT]; // Hard flags

	// Bundle toward the map table
	map_mem_if mem ();

	// Narrowing map table
	map_store store_inst (
		.core_clk(core_clk),
		.rst(rst),
		.mem(mem)
	);

	// Address decode of the captured access
	wire take_req = (acc_q == ACC_IDLE) && reg_valid;
	wire hit_map = (op_offset_q == NARROW_MAP_OFFSET); // RULE12
	wire hit_ceiling = (op_offset_q == BW_CEILING_OFFSET);
	// Selector identifier must fit the request space
	wire req_id_ok = (op_part_q[15:REQ_ID_BITS] == '0);
	// Narrowed selection for the ceiling must fit the narrowed space
	wire int_id_ok = (op_part_q <= NARROWED_ID_LIMIT);
	wire [INT_ID_BITS-1:0] int_sel = op_part_q[INT_ID_BITS-1:0];
	// Instance select is honoured only where instances exist
	wire [RIS_BITS-1:0] ris_sel = RESOURCE_INSTANCES_SUPPORTED ?
		op_ris_q : '0; // RULE13
	// Single cycle in which tables are read and written
	wire in_lookup = (acc_q == ACC_LOOKUP);

	// Narrowing write checks
	wire wr_flag = op_wdata_q[FLAG_BIT];
	wire wr_id_bad = (op_wdata_q[15:0] > NARROWED_ID_LIMIT);
	wire range_err = wr_id_bad || !wr_flag; // RULE4 RULE6
	wire map_access = in_lookup && hit_map;
	// Selector flag set: error raised and map write blocked; a read still answers
	wire unexpected_err = map_access && op_internal_q; // RULE5 RULE11
	wire map_wr_ok = map_access && op_write_q && !op_internal_q &&
		!range_err && req_id_ok; // RULE1 RULE4 RULE6
	// Ceiling writes beyond the narrowed range are dropped
	wire ceil_wr = in_lookup && hit_ceiling && op_write_q && int_id_ok;

	// The map entry is chosen by state and request identifier only
	assign mem.we = map_wr_ok; // RULE9 RULE10
	assign mem.waddr = {op_state_q, op_part_q[REQ_ID_BITS-1:0]};
	assign mem.wdata = op_wdata_q[15:0];
	assign mem.raddr = {op_state_q, op_part_q[REQ_ID_BITS-1:0]}; // RULE11

	// Read data assembled in the answer cycle
	// Selector ids beyond the table read as zero
	wire [15:0] map_id = req_id_ok ? mem.rdata : 16'h0000;
	wire [31:0] map_word = {15'h0000, flag_q[op_state_q], map_id}; // RULE7 RULE8
	wire [FRACTION_WIDTH-1:0] sel_frac =
		frac_q[op_state_q][ris_sel][int_sel];
	wire sel_hard = hard_q[op_state_q][ris_sel][int_sel];
	wire [31:0] ceil_word = int_id_ok ? {sel_hard, 15'h0000, sel_frac,
		{(FRACTION_MSB + 1 - FRACTION_WIDTH){1'b0}}} :
		32'h00000000; // RULE16 RULE17 RULE18
	// Writes and unmapped offsets answer zero
	wire [31:0] read_word = op_write_q ? 32'h00000000 :
		hit_map ? map_word : hit_ceiling ? ceil_word : 32'h00000000;

	// Sequencer: take, look up, answer; one access in flight
	always_comb begin
		acc_d = acc_q;
		case (acc_q)
			ACC_IDLE: begin
				// Requests while busy are dropped, never queued
				if (reg_valid) begin
					acc_d = ACC_LOOKUP;
				end
			end
			ACC_LOOKUP: begin
				// Table and settings are read and written here
				acc_d = ACC_ANSWER;
			end
			ACC_ANSWER: begin
				// Ack leaves at the next edge
				acc_d = ACC_IDLE;
			end
			default: begin
				// Unused code falls back to idle
				acc_d = ACC_IDLE;
			end
		endcase
	end

	// Sequencer state and busy indication
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			acc_q <= ACC_IDLE;
			reg_busy_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			reg_busy_q <= (acc_d != ACC_IDLE);
		end
	end

	// Capture the access with the selector of its own state
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			op_write_q <= 1'b0;
			op_state_q <= SEC_SECURE;
			op_offset_q <= 12'h000;
			op_wdata_q <= 32'h00000000;
			op_part_q <= 16'h0000;
			op_internal_q <= 1'b0;
			op_ris_q <= '0;
		end else if (take_req) begin
			// Only an idle sequencer takes a new access
			op_write_q <= reg_write;
			op_state_q <= reg_state;
			op_offset_q <= reg_offset;
			op_wdata_q <= reg_wdata;
			// Selector was set before this access
			op_part_q <= sel_partition[reg_state]; // RULE2 RULE3
			op_internal_q <= sel_internal[reg_state];
			op_ris_q <= sel_instance[reg_state];
		end
	end

	// Flag mirrors every narrowing write, even a refused one
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int s = 0; s < STATE_COUNT; s++) begin
				flag_q[s] <= FLAG_RESET;
			end
		end else if (map_access && op_write_q) begin
			// Recorded even when the selector flag is set
			flag_q[op_state_q] <= wr_flag; // RULE7
		end
	end

	// Ceiling settings per state, instance and narrowed identifier
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int s = 0; s < STATE_COUNT; s++) begin
				for (int r = 0; r < RES_INSTANCES; r++) begin
					for (int p = 0; p < INT_ID_COUNT; p++) begin
						// Largest fraction, soft limited, after reset
						frac_q[s][r][p] <= FRACTION_RESET;
						hard_q[s][r][p] <= HARD_RESET;
					end
				end
			end
		end else if (ceil_wr) begin
			// Low fraction bits are simply not stored
			frac_q[op_state_q][ris_sel][int_sel] <= op_wdata_q[FRACTION_MSB
				-: FRACTION_WIDTH]; // RULE17 RULE19 RULE13
			hard_q[op_state_q][ris_sel][int_sel] <=
				op_wdata_q[HARD_LIMIT_BIT]; // RULE16
		end
	end

	// Answer and error report
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata_q <= 32'h00000000;
			reg_ack_q <= 1'b0;
			err_event_q <= 1'b0;
			err_code_q <= ERR_NONE;
			err_state_q <= SEC_SECURE;
		end else begin
			reg_ack_q <= (acc_q == ACC_ANSWER);
			// Read data holds until the next answer
			if (acc_q == ACC_ANSWER) begin
				reg_rdata_q <= read_word; // RULE3
			end
			// Unexpected flag outranks a range fault on the same write
			err_event_q <= unexpected_err ||
				(map_access && op_write_q && range_err);
			err_state_q <= op_state_q;
			if (unexpected_err) begin
				err_code_q <= ERR_UNEXPECTED; // RULE5
			end else if (map_access && op_write_q && range_err) begin
				err_code_q <= ERR_RANGE; // RULE4
			end else begin
				err_code_q <= ERR_NONE;
			end
		end
	end

	// Measurement window counter shared by all slots
	logic [WINDOW_BITS-1:0] window_q;
	// Window ends when the counter wraps
	wire window_end = (window_q == {WINDOW_BITS{1'b1}});

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			window_q <= '0;
		end else begin
			window_q <= window_q + 1'b1;
		end
	end

	logic [SLOT_COUNT-1:0] over_now; // Slot over its ceiling now
	logic [SLOT_COUNT-1:0] hard_slot; // Slot uses hard limiting
	logic [SLOT_COUNT-1:0] grant_d; // Grant chosen this cycle

	// Per-slot usage count against ceiling times window length
	// Limits come from instance 0 only; other instances are stored alone
	genvar g;
	generate
		for (g = 0; g < SLOT_COUNT; g++) begin : slot
			logic [WINDOW_BITS:0] used_q; // Grants in this window
			wire [FRACTION_WIDTH-1:0] f =
				frac_q[g / INT_ID_COUNT][REGULATED_INSTANCE][g % INT_ID_COUNT];
			// Fraction below one scaled to the window length
			wire [WINDOW_BITS:0] cap = {1'b0, f,
				{(WINDOW_BITS - FRACTION_WIDTH){1'b0}}}; // RULE18 RULE20
			assign over_now[g] = (used_q >= cap); // RULE20
			assign hard_slot[g] =
				hard_q[g / INT_ID_COUNT][REGULATED_INSTANCE][g % INT_ID_COUNT];
			// Count clears each window so an over slot can recover
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					used_q <= '0;
				end else if (window_end) begin
					used_q <= '0; // RULE15
				end else if (grant_d[g]) begin
					used_q <= used_q + 1'b1;
				end
			end
		end
	endgenerate

	// Under-ceiling slots first; soft over-ceiling ones only if none
	wire [SLOT_COUNT-1:0] under_req = traffic_req & ~over_now;
	wire [SLOT_COUNT-1:0] soft_req = traffic_req & over_now &
		~hard_slot; // RULE14 RULE15
	wire [SLOT_COUNT-1:0] pick = (|under_req) ? under_req : soft_req; // RULE14
	// Lowest requesting slot wins; simple but not fair
	assign grant_d = pick & (~pick + 1'b1);

	// Grant and over-limit status registers
	// A grant lasts one cycle; a held request is granted again
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			grant_q <= '0;
			over_limit_q <= '0;
		end else begin
			grant_q <= grant_d;
			over_limit_q <= over_now;
		end
	end
endmodule

// ---- dv/bw_cap_assertions.sv ----
// Timing and error checks on the narrowing and ceiling block ports
`timescale 1ns/1ps
module bw_cap_assertions
	import bw_cap_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register access
	input wire logic reg_valid,
	input wire logic reg_write,
	input wire logic [1:0] reg_state,
	input wire logic [11:0] reg_offset,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata_q,
	input wire logic reg_ack_q,
	input wire logic reg_busy_q,
	input wire logic sel_internal [STATE_COUNT],
	// Error report and regulator
	input wire logic err_event_q,
	input wire logic [1:0] err_code_q,
	input wire logic [1:0] err_state_q,
	input wire logic [SLOT_COUNT-1:0] traffic_req,
	input wire logic [SLOT_COUNT-1:0] grant_q
);
	// Request taken only while the sequencer is idle
	wire take = reg_valid && !reg_busy_q;
	wire map_hit = take && reg_offset == NARROW_MAP_OFFSET;
	wire int_set = sel_internal[reg_state];
	// Written value the map must refuse
	wire bad_val = !reg_wdata[FLAG_BIT] || reg_wdata[15:0] > NARROWED_ID_LIMIT;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence take_s;
		take;
	endsequence
	// Two busy cycles, then the answer
	sequence answer_s;
		reg_busy_q ##1 reg_busy_q ##1 (reg_ack_q && !reg_busy_q);
	endsequence
	ack_timing_a: assert property (take_s |=> answer_s)
		else $error("access answer timing wrong");
	ack_pulse_a: assert property (reg_ack_q |=> !reg_ack_q)
		else $error("ack longer than one cycle");
	err_lead_a: assert property (err_event_q |=> reg_ack_q)
		else $error("error pulse not followed by ack");
	unexpected_flag_a: assert property (map_hit && int_set |=> ##1
		(err_event_q && err_code_q == ERR_UNEXPECTED))
		else $error("internal flag access not reported");
	range_error_a: assert property (map_hit && reg_write && !int_set &&
		bad_val |=> ##1 (err_event_q && err_code_q == ERR_RANGE))
		else $error("range error not reported");
	clean_map_a: assert property (map_hit && !int_set &&
		!(reg_write && bad_val) |=> ##1 !err_event_q)
		else $error("error on a legal map access");
	err_state_a: assert property (take_s |=> ##1
		(err_event_q |-> err_state_q == $past(reg_state, 2)))
		else $error("error frame wrong");
	write_zero_a: assert property (take && reg_write |=> ##2
		reg_rdata_q == 32'h00000000)
		else $error("write answered with data");
	reserved_zero_a: assert property (reg_ack_q |->
		reg_rdata_q[30:17] == 14'h0000)
		else $error("reserved bits not zero");
	grant_onehot_a: assert property ($onehot0(grant_q))
		else $error("more than one grant");
	grant_req_a: assert property ((grant_q & ~$past(traffic_req)) == 0)
		else $error("grant without request");
endmodule
bind partition_narrowing_bw_cap bw_cap_assertions chk (
	.core_clk(core_clk), .rst(rst), .reg_valid(reg_valid),
	.reg_write(reg_write), .reg_state(reg_state), .reg_offset(reg_offset),
	.reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q),
	.reg_busy_q(reg_busy_q), .sel_internal(sel_internal),
	.err_event_q(err_event_q), .err_code_q(err_code_q),
	.err_state_q(err_state_q), .traffic_req(traffic_req), .grant_q(grant_q)
);

// ---- dv/tb.sv ----
// Self-checking bench for the narrowing map and bandwidth ceiling block
`timescale 1ns/1ps
module tb;
	import bw_cap_pkg::*;
	logic core_clk, rst, reg_valid, reg_write, reg_ack_q, reg_busy_q;
	logic [1:0] reg_state, err_code_q, err_state_q, seen_err;
	logic [11:0] reg_offset;
	logic [31:0] reg_wdata, reg_rdata_q, v;
	logic err_event_q;
	logic [15:0] sel_partition [STATE_COUNT];
	logic sel_internal [STATE_COUNT];
	logic [RIS_BITS-1:0] sel_instance [STATE_COUNT];
	logic [SLOT_COUNT-1:0] traffic_req, grant_q, over_limit_q;
	logic [33:0] exp_q [$]; // Expected {error code, read data}
	logic [2:0] ids [STATE_COUNT]; // Narrowed id written per frame
	int bad_count, n_compared;
	partition_narrowing_bw_cap dut (.*);
	// Free-running 25 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic check(logic [33:0] seen, logic [33:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Monitor: error pulse comes one cycle ahead of the ack; outputs are
	// read at the falling edge, half a cycle after they settle
	always @(negedge core_clk) begin
		if (rst) begin
			seen_err <= ERR_NONE;
		end else begin
			if (err_event_q === 1'b1) seen_err <= err_code_q;
			if (reg_ack_q === 1'b1 && exp_q.size() == 0) begin
				bad_count++;
				$display("FAIL %0t answer with nothing expected", $time);
			end else if (reg_ack_q === 1'b1) begin
				check({seen_err, reg_rdata_q}, exp_q.pop_front());
				seen_err <= ERR_NONE;
			end
		end
	end
	// Selector fields of one frame
	task automatic sel(int s, int id, int in, int ri);
		sel_partition[s] = 16'(id);
		sel_internal[s] = 1'(in);
		sel_instance[s] = RIS_BITS'(ri);
	endtask
	// One access; next may start at the ack cycle
	task automatic acc(int w, int s, logic [11:0] o, logic [31:0] d,
		logic [31:0] e, logic [1:0] er);
		exp_q.push_back({er, e});
		reg_valid = 1'b1;
		reg_write = (w != 0);
		reg_state = 2'(s);
		reg_offset = o;
		reg_wdata = d;
		@(negedge core_clk);
		reg_valid = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask
	// Hold traffic and compare grants for a few cycles
	task automatic run(logic [31:0] req, logic [31:0] g);
		traffic_req = req;
		@(negedge core_clk);
		repeat (6) begin
			@(negedge core_clk);
			check({2'b00, grant_q}, {2'b00, g});
		end
		traffic_req = 32'h00000000;
	endtask
	task automatic close_out;
		// An answer still owed counts as a mismatch
		if (exp_q.size() != 0) bad_count++;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog well past the expected run length
	initial begin
		#200000;
		bad_count++;
		close_out();
	end
	initial begin
		v = $urandom(32'h4995);
		{rst, reg_valid, reg_write, reg_state} = 5'h10;
		{reg_offset, reg_wdata, traffic_req} = '0;
		for (int s = 0; s < 4; s++) sel(s, 0, 0, 0);
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
		acc(0, 0, NARROW_MAP_OFFSET, 0, 32'h00000000, ERR_NONE);
		acc(0, 0, BW_CEILING_OFFSET, 0, 32'h0000E000, ERR_NONE);
		acc(0, 0, 12'h004, 0, 32'h00000000, ERR_NONE);
		// Every frame, random id; resource select flipped on readback
		// Same request id in all frames, a distinct narrowed id in each
		for (int s = 0; s < 4; s++) begin
			ids[s] = {1'($urandom_range(1)), 2'(s)};
			sel(s, 3, 0, $urandom_range(1));
			v = {16'h0001, 13'h0, ids[s]};
			acc(1, s, NARROW_MAP_OFFSET, v, 0, ERR_NONE);
		end
		for (int s = 0; s < 4; s++) begin
			sel(s, 3, 0, ~sel_instance[s]);
			v = {16'h0001, 13'h0, ids[s]};
			acc(0, s, NARROW_MAP_OFFSET, 0, v, ERR_NONE);
		end
		// Refused writes leave the association; flag reads back
		acc(1, 0, NARROW_MAP_OFFSET, 32'h00000005, 0, ERR_RANGE);
		acc(0, 0, NARROW_MAP_OFFSET, 0, {29'h0, ids[0]}, ERR_NONE);
		acc(1, 0, NARROW_MAP_OFFSET, 32'h00010008, 0, ERR_RANGE);
		sel(0, 3, 1, 0);
		acc(1, 0, NARROW_MAP_OFFSET, 32'h00010002, 0, ERR_UNEXPECTED);
		v = {16'h0001, 13'h0, ids[0]};
		acc(0, 0, NARROW_MAP_OFFSET, 0, v, ERR_UNEXPECTED);
		sel(0, 3, 0, 0);
		acc(0, 0, NARROW_MAP_OFFSET, 0, v, ERR_NONE);
		// Ceiling per instance and frame; low fraction bits dropped
		sel(0, 2, 0, 1);
		acc(1, 0, BW_CEILING_OFFSET, 32'hFFFFBFFF, 0, ERR_NONE);
		acc(0, 0, BW_CEILING_OFFSET, 0, 32'h8000A000, ERR_NONE);
		sel(1, 2, 0, 1);
		acc(0, 1, BW_CEILING_OFFSET, 0, 32'h0000E000, ERR_NONE);
		sel(0, 2, 0, 0);
		acc(0, 0, BW_CEILING_OFFSET, 0, 32'h0000E000, ERR_NONE);
		// Slot 1 hard limited at zero: never served
		sel(0, 1, 0, 0);
		acc(1, 0, BW_CEILING_OFFSET, 32'h80000000, 0, ERR_NONE);
		run(32'h00000002, 32'h00000000);
		check({33'h0, over_limit_q[1]}, 34'h1);
		run(32'h00000006, 32'h00000004);
		// Soft limit: over slot served only when alone
		acc(1, 0, BW_CEILING_OFFSET, 32'h00000000, 0, ERR_NONE);
		run(32'h00000002, 32'h00000002);
		run(32'h00000006, 32'h00000004);
		repeat (2) @(negedge core_clk);
		close_out();
	end
endmodule
